// ==== hpgc_pkg.sv ====
// Package of constants and carrier types for the host port pin GPIO controller.
`default_nettype none

package hpgc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Bus geometry.
	localparam int unsigned ADR_W  = 8;
	localparam int unsigned DAT_W  = 32;
	localparam int unsigned REG_W  = 16;
	localparam int unsigned CTRL_N = 9;
	localparam int unsigned ADDR_N = 16;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets.
	localparam logic [ADR_W-1:0] OFS_CTRL_DIR  = 8'h00;
	localparam logic [ADR_W-1:0] OFS_CTRL_DAT  = 8'h04;
	localparam logic [ADR_W-1:0] OFS_ADDR_DIR  = 8'h08;
	localparam logic [ADR_W-1:0] OFS_ADDR_DAT  = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_IRQ_EN    = 8'h10;
	localparam logic [ADR_W-1:0] OFS_IRQ_INV   = 8'h14;
	localparam logic [ADR_W-1:0] OFS_EMU       = 8'h18;
	localparam logic [ADR_W-1:0] OFS_EVT_STAT  = 8'h1C;
	localparam logic [ADR_W-1:0] OFS_EVT_MASK  = 8'h20;

	////////////////////////////////////////////////////////////////////////////
	// Writable bits of each register; all else reads zero.
	localparam logic [REG_W-1:0] MASK_CTRL = 16'h01FF;
	localparam logic [REG_W-1:0] MASK_ADDR = 16'hFFFF;
	localparam logic [REG_W-1:0] MASK_IRQ  = 16'h0004;
	localparam logic [REG_W-1:0] MASK_EMU  = 16'h0003;
	localparam logic [REG_W-1:0] MASK_EVT  = 16'h0007;
	localparam logic [REG_W-1:0] REG_RST   = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int unsigned B_HOST_IRQ   = 8;
	localparam int unsigned B_CTL_A      = 7;
	localparam int unsigned B_CTL_B      = 6;
	localparam int unsigned B_BYTE_ID    = 5;
	localparam int unsigned B_RD_WR      = 4;
	localparam int unsigned B_STROBE_TWO = 3;
	localparam int unsigned B_STROBE_ONE = 2;
	localparam int unsigned B_CHIP_SEL   = 1;
	localparam int unsigned B_ADDR_STB   = 0;
	localparam int unsigned B_IRQ_STB    = 2;
	localparam int unsigned B_EMU_FREE   = 0;
	localparam int unsigned B_EMU_SOFT   = 1;
	localparam int unsigned B_EV_STB     = 0;
	localparam int unsigned B_EV_HOST    = 1;
	localparam int unsigned B_EV_HALT    = 2;
	// Bits of the GPIO enable word supplied by the neighbouring enable register.
	localparam int unsigned EN_STROBES   = 0;
	localparam int unsigned EN_CTL       = 1;
	localparam int unsigned EN_ADDR_STB  = 2;
	localparam int unsigned EN_BYTE_ID   = 4;
	localparam int unsigned EN_HOST_IRQ  = 6;
	localparam int unsigned EN_ADDR_LO   = 11;
	localparam int unsigned EN_ADDR_HI   = 12;
	localparam int unsigned BANK_W       = 8;

	////////////////////////////////////////////////////////////////////////////
	// Pin drive carriers.
	typedef struct packed {
		logic [CTRL_N-1:0] out;
		logic [CTRL_N-1:0] oe;
	} hpgc_ctrl_drv_t;

	typedef struct packed {
		logic [ADDR_N-1:0] out;
		logic [ADDR_N-1:0] oe;
	} hpgc_addr_drv_t;

	typedef enum logic [1:0] {
		EMU_RUN,
		EMU_DRAIN,
		EMU_HALTED
	} hpgc_emu_state_t;

endpackage : hpgc_pkg

`default_nettype wire

// ==== hpgc_top.sv ====
// Host port pin GPIO controller: control and address pin GPIO, strobe interrupt, emulation suspend.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module hpgc_top
	import hpgc_pkg::*;
#(
	parameter bit HAS_ADDR_PINS = 1'b1
) (
	// Clock and reset.
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone classic slave.
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [ADR_W-1:0]    adr_i,
	input  wire logic [DAT_W/8-1:0]  sel_i,
	input  wire logic [DAT_W-1:0]    dat_i,
	output var  logic [DAT_W-1:0]    dat_o,
	output var  logic                ack_o,
	// Configuration from neighbouring logic on this clock.
	input  wire logic [REG_W-1:0]    pin_gpio_enable_i,
	input  wire logic                mux_mode_i,
	input  wire logic                host_to_cpu_irq_bit_i,
	// Emulation and DMA handshake.
	input  wire logic                emu_suspend_i,
	input  wire logic                dma_busy_i,
	output var  logic                dma_halt_o,
	// Port pins.
	input  wire logic                port_enable_input_i,
	input  wire logic [CTRL_N-1:0]   ctrl_pins_i,
	output var  hpgc_ctrl_drv_t      ctrl_pins_o,
	input  wire logic [ADDR_N-1:0]   port_addr_pins_i,
	output var  hpgc_addr_drv_t      port_addr_pins_o,
	// Interrupts.
	output var  logic                cpu_irq_o,
	output var  logic                irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// Registers and internal signals.
	logic [REG_W-1:0]  ctrl_dir_reg;
	logic [REG_W-1:0]  ctrl_dat_reg;
	logic [REG_W-1:0]  addr_dir_reg;
	logic [REG_W-1:0]  addr_dat_reg;
	logic [REG_W-1:0]  irq_en_reg;
	logic [REG_W-1:0]  irq_inv_reg;
	logic [REG_W-1:0]  emu_reg;
	logic [REG_W-1:0]  evt_stat_reg;
	logic [REG_W-1:0]  evt_mask_reg;
	logic [CTRL_N-1:0] ctrl_meta_reg;
	logic [CTRL_N-1:0] ctrl_sync_reg;
	logic [ADDR_N-1:0] addr_meta_reg;
	logic [ADDR_N-1:0] addr_sync_reg;
	logic              pena_meta_reg;
	logic              pena_sync_reg;
	logic              stb_req_reg;
	logic              host_bit_reg;
	hpgc_emu_state_t   emu_state_reg;
	hpgc_emu_state_t   emu_state_next;
	logic              bus_req;
	logic              bus_wr;
	logic [REG_W-1:0]  byte_mask;
	logic [REG_W-1:0]  wr_word;
	logic [CTRL_N-1:0] ctrl_avail;
	logic [ADDR_N-1:0] addr_avail;
	logic [REG_W-1:0]  ctrl_rd_val;
	logic [REG_W-1:0]  addr_rd_val;
	logic              stb_req;
	logic              ev_strobe;
	logic              ev_host;
	logic              ev_halt;
	logic [REG_W-1:0]  ev_vec;
	logic              addr_present;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the first stage feeds only the second.
	// Pins arrive with no relation to clk_i, so no logic may read the first
	// stage. The cost is two cycles of latency on every pin level, which
	// software sees as a short delay before a read shows a new level.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_meta_reg <= '0;
			ctrl_sync_reg <= '0;
			addr_meta_reg <= '0;
			addr_sync_reg <= '0;
			pena_meta_reg <= 1'b0;
			pena_sync_reg <= 1'b0;
		end else begin
			ctrl_meta_reg <= ctrl_pins_i;
			ctrl_sync_reg <= ctrl_meta_reg;
			addr_meta_reg <= port_addr_pins_i;
			addr_sync_reg <= addr_meta_reg;
			pena_meta_reg <= port_enable_input_i;
			pena_sync_reg <= pena_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus decode. Only the CPU bus reaches these registers; no pin path writes them.
	// A request is masked while ack_o is high, so a master that keeps stb_i up
	// for one more cycle is never taken twice. Only the two low byte lanes
	// carry register bits; the upper half of the data bus is ignored.
	assign bus_req      = cyc_i & stb_i & ~ack_o;
	assign bus_wr       = bus_req & we_i;
	assign byte_mask    = {{BANK_W{sel_i[1]}}, {BANK_W{sel_i[0]}}};
	assign wr_word      = dat_i[REG_W-1:0];
	assign addr_present = HAS_ADDR_PINS;

	// Masked merge of a write into a register, honouring byte lanes and reserved bits.
	// Reserved bits are never stored, so they read zero whatever is written.
	function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_val,
	                                           input logic [REG_W-1:0] keep);
		logic [REG_W-1:0] m;
		m = byte_mask & keep;
		return (old_val & ~m) | (wr_word & m);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Per-pin availability: mode, bank enable and port enable conditions.
	// A pin that is not available keeps its register bits but is never driven.
	// The strobe group follows the synchronised port enable pin, so a host
	// that enables the port takes these pins back within three cycles.
	// The address strobe and byte-identify pins exist only in multiplexed mode.
	always_comb begin
		ctrl_avail                = '0;
		ctrl_avail[B_HOST_IRQ]    = pin_gpio_enable_i[EN_HOST_IRQ];
		ctrl_avail[B_CTL_A]       = pin_gpio_enable_i[EN_CTL];
		ctrl_avail[B_CTL_B]       = pin_gpio_enable_i[EN_CTL];
		ctrl_avail[B_BYTE_ID]     = pin_gpio_enable_i[EN_BYTE_ID] & mux_mode_i;
		ctrl_avail[B_ADDR_STB]    = pin_gpio_enable_i[EN_ADDR_STB] & mux_mode_i;
		ctrl_avail[B_RD_WR]       = pin_gpio_enable_i[EN_STROBES] & ~pena_sync_reg;
		ctrl_avail[B_STROBE_TWO]  = pin_gpio_enable_i[EN_STROBES] & ~pena_sync_reg;
		ctrl_avail[B_STROBE_ONE]  = pin_gpio_enable_i[EN_STROBES] & ~pena_sync_reg;
		ctrl_avail[B_CHIP_SEL]    = pin_gpio_enable_i[EN_STROBES] & ~pena_sync_reg;
	end

	// Address pins need their bank, non-multiplexed mode and a part that has them.
	// In multiplexed mode these pins do not exist, so both banks are held off.
	assign addr_avail = {{BANK_W{pin_gpio_enable_i[EN_ADDR_HI]}},
	                     {BANK_W{pin_gpio_enable_i[EN_ADDR_LO]}}}
	                    & {ADDR_N{~mux_mode_i & addr_present}};

	////////////////////////////////////////////////////////////////////////////
	// Direction and configuration registers.
	// Only the word address is decoded; the two low address bits are ignored.
	// On the variant without address pins, writes to their direction word
	// are dropped so that the location behaves as reserved.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_dir_reg <= REG_RST;
			addr_dir_reg <= REG_RST;
			irq_en_reg   <= REG_RST;
			irq_inv_reg  <= REG_RST;
			emu_reg      <= REG_RST;
			evt_mask_reg <= REG_RST;
		end else if (bus_wr) begin
			case ({adr_i[ADR_W-1:2], 2'b00})
				OFS_CTRL_DIR: ctrl_dir_reg <= merge(ctrl_dir_reg, MASK_CTRL);
				OFS_ADDR_DIR: begin
					if (addr_present) begin
						addr_dir_reg <= merge(addr_dir_reg, MASK_ADDR);
					end
				end
				OFS_IRQ_EN:   irq_en_reg   <= merge(irq_en_reg, MASK_IRQ);
				OFS_IRQ_INV:  irq_inv_reg  <= merge(irq_inv_reg, MASK_IRQ);
				OFS_EMU:      emu_reg      <= merge(emu_reg, MASK_EMU);
				OFS_EVT_MASK: evt_mask_reg <= merge(evt_mask_reg, MASK_EVT);
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data registers: only bits set as outputs accept a write.
	// An input bit keeps its stored value, so turning the pin back into an
	// output drives the last value written while it was an output.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_dat_reg <= REG_RST;
			addr_dat_reg <= REG_RST;
		end else if (bus_wr) begin
			if ({adr_i[ADR_W-1:2], 2'b00} == OFS_CTRL_DAT) begin
				ctrl_dat_reg <= merge(ctrl_dat_reg, MASK_CTRL & ctrl_dir_reg);
			end
			if (({adr_i[ADR_W-1:2], 2'b00} == OFS_ADDR_DAT) && addr_present) begin
				addr_dat_reg <= merge(addr_dat_reg, MASK_ADDR & addr_dir_reg);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read views: output bits show the stored value, input bits the pin level.
	// Input bits show the level whether or not the pin is enabled for GPIO,
	// so software can watch a pin that the port still uses.
	assign ctrl_rd_val = ((ctrl_dat_reg & ctrl_dir_reg)
	                     | ({{(REG_W-CTRL_N){1'b0}}, ctrl_sync_reg} & ~ctrl_dir_reg)) & MASK_CTRL;
	assign addr_rd_val = addr_present
	                     ? ((addr_dat_reg & addr_dir_reg) | (addr_sync_reg & ~addr_dir_reg))
	                     : REG_RST;

	////////////////////////////////////////////////////////////////////////////
	// Pin drivers. A pin is driven only when it is an available GPIO output.
	// Value and enable are both registered, so a register write reaches the
	// pins one cycle later and the pins never glitch on decode.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_pins_o      <= '0;
			port_addr_pins_o <= '0;
		end else begin
			ctrl_pins_o.out      <= ctrl_dat_reg[CTRL_N-1:0];
			ctrl_pins_o.oe       <= ctrl_dir_reg[CTRL_N-1:0] & ctrl_avail;
			port_addr_pins_o.out <= addr_dat_reg;
			port_addr_pins_o.oe  <= addr_dir_reg & addr_avail;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strobe interrupt: a level request qualified by enable, mode and direction.
	// A pin set as output cannot interrupt, so software driving the strobe pin
	// itself never raises a request. The invert bit selects the active level.
	assign stb_req = irq_en_reg[B_IRQ_STB]
	                 & ctrl_avail[B_ADDR_STB]
	                 & ~ctrl_dir_reg[B_ADDR_STB]
	                 & (ctrl_sync_reg[B_ADDR_STB] ~^ irq_inv_reg[B_IRQ_STB]);

	// The request is edge-detected so a held level raises one interrupt, like the host bit.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stb_req_reg  <= 1'b0;
			host_bit_reg <= 1'b0;
		end else begin
			stb_req_reg  <= stb_req;
			host_bit_reg <= host_to_cpu_irq_bit_i;
		end
	end

	assign ev_strobe = stb_req & ~stb_req_reg;
	assign ev_host   = host_to_cpu_irq_bit_i & ~host_bit_reg;

	// One shared CPU interrupt pulse for both sources.
	// Two events in one cycle give the CPU a single pulse; the status bits
	// tell the two causes apart.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_irq_o <= 1'b0;
		end else begin
			cpu_irq_o <= ev_strobe | ev_host;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Emulation suspend. Soft stop waits for current transfers to drain.
	// The free bit wins over the soft bit. Leaving suspend, setting free or
	// clearing soft releases the halt at once, even while draining.
	always_comb begin
		emu_state_next = emu_state_reg;
		case (emu_state_reg)
			EMU_RUN: begin
				if (emu_suspend_i && !emu_reg[B_EMU_FREE] && emu_reg[B_EMU_SOFT]) begin
					emu_state_next = EMU_DRAIN;
				end
			end
			EMU_DRAIN: begin
				if (!emu_suspend_i || emu_reg[B_EMU_FREE] || !emu_reg[B_EMU_SOFT]) begin
					emu_state_next = EMU_RUN;
				end else if (!dma_busy_i) begin
					emu_state_next = EMU_HALTED;
				end
			end
			EMU_HALTED: begin
				if (!emu_suspend_i || emu_reg[B_EMU_FREE] || !emu_reg[B_EMU_SOFT]) begin
					emu_state_next = EMU_RUN;
				end
			end
			default: emu_state_next = EMU_RUN;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			emu_state_reg <= EMU_RUN;
			dma_halt_o    <= 1'b0;
		end else begin
			emu_state_reg <= emu_state_next;
			dma_halt_o    <= (emu_state_next == EMU_HALTED);
		end
	end

	assign ev_halt = (emu_state_next == EMU_HALTED) && (emu_state_reg != EMU_HALTED);

	////////////////////////////////////////////////////////////////////////////
	// Event status: sticky, write one to clear, a new event wins over its clear.
	// Letting the event win means a clear that races a new event loses nothing.
	always_comb begin
		ev_vec              = '0;
		ev_vec[B_EV_STB]    = ev_strobe;
		ev_vec[B_EV_HOST]   = ev_host;
		ev_vec[B_EV_HALT]   = ev_halt;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_stat_reg <= REG_RST;
		end else if (bus_wr && ({adr_i[ADR_W-1:2], 2'b00} == OFS_EVT_STAT)) begin
			evt_stat_reg <= ((evt_stat_reg & ~(wr_word & byte_mask)) | ev_vec) & MASK_EVT;
		end else begin
			evt_stat_reg <= (evt_stat_reg | ev_vec) & MASK_EVT;
		end
	end

	// Level interrupt, one cycle behind the status it reflects.
	// Registering it keeps the output free of decode glitches at the cost
	// of one cycle of latency.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(evt_stat_reg & evt_mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus answer: ack one cycle after the request, dropped the next cycle.
	// Unmapped and reserved addresses read zero and ignore writes.
	// Read data is zero outside the acknowledge cycle, so a bus that ORs the
	// read data of several slaves never sees a stale value.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= bus_req;
			dat_o <= '0;
			if (bus_req && !we_i) begin
				case ({adr_i[ADR_W-1:2], 2'b00})
					OFS_CTRL_DIR: dat_o <= {16'h0000, ctrl_dir_reg};
					OFS_CTRL_DAT: dat_o <= {16'h0000, ctrl_rd_val};
					OFS_ADDR_DIR: dat_o <= {16'h0000, addr_present ? addr_dir_reg : REG_RST};
					OFS_ADDR_DAT: dat_o <= {16'h0000, addr_rd_val};
					OFS_IRQ_EN:   dat_o <= {16'h0000, irq_en_reg};
					OFS_IRQ_INV:  dat_o <= {16'h0000, irq_inv_reg};
					OFS_EMU:      dat_o <= {16'h0000, emu_reg};
					OFS_EVT_STAT: dat_o <= {16'h0000, evt_stat_reg};
					OFS_EVT_MASK: dat_o <= {16'h0000, evt_mask_reg};
					default:      dat_o <= '0;
				endcase
			end
		end
	end

endmodule // hpgc_top

`default_nettype wire

// ==== hpgc_checker.sv ====
// Concurrent checks on the bus and pins of the host port pin GPIO controller.
`default_nettype none
////////////////////////////////////////
module hpgc_checker
	import hpgc_pkg::*;
#(
	parameter bit HAS_ADDR_PINS = 1'b1
) (
	// Clock, reset and bus.
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic             cyc_i,
	input wire logic             stb_i,
	input wire logic             we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [DAT_W-1:0] dat_o,
	input wire logic             ack_o,
	// Configuration, emulation and pins.
	input wire logic [REG_W-1:0] pin_gpio_enable_i,
	input wire logic             mux_mode_i,
	input wire logic             host_to_cpu_irq_bit_i,
	input wire logic             emu_suspend_i,
	input wire logic             dma_busy_i,
	input wire logic             dma_halt_o,
	input wire logic             port_enable_input_i,
	input wire hpgc_ctrl_drv_t   ctrl_pins_o,
	input wire hpgc_addr_drv_t   port_addr_pins_o,
	input wire logic             cpu_irq_o,
	input wire logic             irq_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// One clock domain, so every check shares the clock; all but the reset check are quiet in reset.
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Bus answers come one cycle after the take and last one cycle.
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request unanswered");
	read_idle_a: assert property (!ack_o |-> dat_o == '0) else $error("read data outside ack");
	irq_resv_a: assert property (ack_o && $past(!we_i && adr_i == OFS_IRQ_EN) |->
		(dat_o[REG_W-1:0] & ~MASK_IRQ) == '0) else $error("reserved enable bits read back");
	// Reset is watched while it is high, so this one overrides the default disable.
	rst_clear_a: assert property (disable iff (1'b0) rst_i |=> ctrl_pins_o == '0 &&
		port_addr_pins_o == '0 && !irq_o && !cpu_irq_o && !dma_halt_o) else $error("reset left state");
	host_irq_a: assert property ($rose(host_to_cpu_irq_bit_i) |=> cpu_irq_o) else $error("host bit lost");
	// Pin drive must have been allowed by enable and mode at the previous edge.
	addr_lo_a: assert property (|port_addr_pins_o.oe[7:0] |-> HAS_ADDR_PINS &&
		$past(pin_gpio_enable_i[EN_ADDR_LO] && !mux_mode_i)) else $error("low bank driven");
	addr_hi_a: assert property (|port_addr_pins_o.oe[15:8] |-> HAS_ADDR_PINS &&
		$past(pin_gpio_enable_i[EN_ADDR_HI] && !mux_mode_i)) else $error("high bank driven");
	strobe_pin_a: assert property (ctrl_pins_o.oe[B_ADDR_STB] |->
		$past(mux_mode_i && pin_gpio_enable_i[EN_ADDR_STB])) else $error("strobe pin driven");
	portena_a: assert property (port_enable_input_i [*4] |->
		ctrl_pins_o.oe[B_RD_WR:B_CHIP_SEL] == '0) else $error("port pins driven while enabled");
	halt_exit_a: assert property (!emu_suspend_i [*3] |-> !dma_halt_o) else $error("halt without suspend");
	halt_entry_a: assert property ($rose(dma_halt_o) |-> $past(emu_suspend_i) &&
		!($past(dma_busy_i) && $past(dma_busy_i, 2))) else $error("halt while busy");

	// Main scenarios reached.
	cover property (cpu_irq_o);
	cover property ($rose(dma_halt_o));
	cover property (irq_o);
endmodule // hpgc_checker

bind hpgc_top hpgc_checker #(.HAS_ADDR_PINS(HAS_ADDR_PINS)) i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .dat_o, .ack_o, .pin_gpio_enable_i, .mux_mode_i, .host_to_cpu_irq_bit_i, .emu_suspend_i,
	.dma_busy_i, .dma_halt_o, .port_enable_input_i, .ctrl_pins_o, .port_addr_pins_o, .cpu_irq_o, .irq_o);
`default_nettype wire

// ==== hpgc_pin_model.sv ====
// Board-side model of the host that owns the port pins the controller leaves alone.
`default_nettype none
////////////////////////////////////////
module hpgc_pin_model
	import hpgc_pkg::*;
(
	// Drive from the controller.
	input  wire hpgc_ctrl_drv_t    ctrl_drv_i,
	input  wire hpgc_addr_drv_t    addr_drv_i,
	// Levels the host puts on pins it owns.
	input  wire logic [CTRL_N-1:0] host_ctrl_i,
	input  wire logic [ADDR_N-1:0] host_addr_i,
	// Resolved wire levels.
	output var  logic [CTRL_N-1:0] ctrl_lvl_o,
	output var  logic [ADDR_N-1:0] addr_lvl_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// A driven pin shows the controller's level; the host yields so no wire ever resolves to contention.
	assign ctrl_lvl_o = (ctrl_drv_i.out & ctrl_drv_i.oe) | (host_ctrl_i & ~ctrl_drv_i.oe);
	assign addr_lvl_o = (addr_drv_i.out & addr_drv_i.oe) | (host_addr_i & ~addr_drv_i.oe);
endmodule // hpgc_pin_model
`default_nettype wire

// ==== hpgc_top_test.sv ====
// Self-checking bench for the host port pin GPIO controller.
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
////////////////////////////////////////
module hpgc_top_test import hpgc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic                clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cpu_irq_o, irq_o;
	logic                mux_mode_i, host_to_cpu_irq_bit_i, emu_suspend_i, dma_busy_i;
	logic                dma_halt_o, port_enable_input_i;
	logic [ADR_W-1:0]    adr_i;
	logic [DAT_W/8-1:0]  sel_i;
	logic [DAT_W-1:0]    dat_i, dat_o, q, q_var, var_dat;
	logic [REG_W-1:0]    pin_gpio_enable_i;
	logic [CTRL_N-1:0]   ctrl_pins_i, host_ctrl;
	logic [ADDR_N-1:0]   port_addr_pins_i, host_addr;
	hpgc_ctrl_drv_t      ctrl_pins_o;
	hpgc_addr_drv_t      port_addr_pins_o, var_addr;
	int                  mismatches, check_count, pulses;

	hpgc_top #(.HAS_ADDR_PINS(1'b1)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .pin_gpio_enable_i, .mux_mode_i, .host_to_cpu_irq_bit_i, .emu_suspend_i, .dma_busy_i,
		.dma_halt_o, .port_enable_input_i, .ctrl_pins_i, .ctrl_pins_o, .port_addr_pins_i, .port_addr_pins_o,
		.cpu_irq_o, .irq_o);
	hpgc_pin_model i_host (.ctrl_drv_i(ctrl_pins_o), .addr_drv_i(port_addr_pins_o), .host_ctrl_i(host_ctrl),
		.host_addr_i(host_addr), .ctrl_lvl_o(ctrl_pins_i), .addr_lvl_o(port_addr_pins_i));
	// Variant without address pins, in lockstep on the same bus, for the reserved locations.
	hpgc_top #(.HAS_ADDR_PINS(1'b0)) i_dut_var (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o(var_dat), .ack_o(), .pin_gpio_enable_i, .mux_mode_i, .host_to_cpu_irq_bit_i, .emu_suspend_i,
		.dma_busy_i, .dma_halt_o(), .port_enable_input_i, .ctrl_pins_i, .ctrl_pins_o(), .port_addr_pins_i,
		.port_addr_pins_o(var_addr), .cpu_irq_o(), .irq_o());

	// A 40 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Interrupt pulses last one cycle, so they are counted rather than polled.
	always @(posedge clk_i) begin
		if (cpu_irq_o === 1'b1) pulses++;
	end

	// One classic cycle; the request stays put until ack is seen at a rising edge.
	task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [REG_W-1:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= {16'h0000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		q_var = var_dat;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [ADR_W-1:0] a, input logic [REG_W-1:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rd(input logic [ADR_W-1:0] a, input logic [REG_W-1:0] e);
		wb(1'b0, a, 16'h0000);
		`CHK(q, {16'h0000, e})
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// The verdict is printed in this one place.
	task automatic summarize();
		if (mismatches == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles.
	initial begin
		tick(5000);
		mismatches++;
		summarize();
	end

	// Main sequence.
	initial begin
		rst_i = 1'b1;
		sel_i = 4'h3;
		{cyc_i, stb_i, we_i, adr_i, dat_i, mux_mode_i, host_to_cpu_irq_bit_i, emu_suspend_i, dma_busy_i,
			port_enable_input_i, pin_gpio_enable_i, host_ctrl, host_addr} = '0;
		tick(12);
		rst_i <= 1'b0;
		// Every register clears, and the gap at 24h reads zero.
		for (int a = 0; a < 'h28; a += 4) rd(8'(a), 16'h0000);
		wr(8'h24, 16'h00FF);
		rd(8'h24, 16'h0000);
		// Control pins as outputs in multiplexed mode.
		pin_gpio_enable_i <= 16'h0057;
		mux_mode_i <= 1'b1;
		wr(OFS_CTRL_DIR, 16'h01FF);
		wr(OFS_CTRL_DAT, 16'h01A5);
		tick(2);
		`CHK(ctrl_pins_o.oe, 9'h1FF)
		`CHK(ctrl_pins_o.out, 9'h1A5)
		rd(OFS_CTRL_DAT, 16'h01A5);
		port_enable_input_i <= 1'b1;
		tick(5);
		`CHK(ctrl_pins_o.oe, 9'h1E1)
		port_enable_input_i <= 1'b0;
		mux_mode_i <= 1'b0;
		tick(5);
		`CHK(ctrl_pins_o.oe, 9'h1DE)
		// Inputs read the pin and ignore writes; the old value drives again later.
		wr(OFS_CTRL_DIR, 16'h0000);
		host_ctrl <= 9'h0AA;
		wr(OFS_CTRL_DAT, 16'h0155);
		tick(3);
		rd(OFS_CTRL_DAT, 16'h00AA);
		wr(OFS_CTRL_DIR, 16'h01FF);
		tick(2);
		`CHK(ctrl_pins_o.out & ctrl_pins_o.oe, 9'h184)
		// Address pins per bank and mode.
		pin_gpio_enable_i <= 16'h0800;
		wr(OFS_ADDR_DIR, 16'hFFFF);
		wr(OFS_ADDR_DAT, 16'h5AC3);
		tick(2);
		`CHK(port_addr_pins_o.oe, 16'h00FF)
		`CHK(port_addr_pins_o.out[7:0], 8'hC3)
		pin_gpio_enable_i <= 16'h1800;
		tick(2);
		`CHK(port_addr_pins_o.oe, 16'hFFFF)
		`CHK(port_addr_pins_o.out, 16'h5AC3)
		`CHK(var_addr.oe, 16'h0000)
		rd(OFS_ADDR_DIR, 16'hFFFF);
		`CHK(q_var, 32'h00000000)
		mux_mode_i <= 1'b1;
		tick(2);
		`CHK(port_addr_pins_o.oe, 16'h0000)
		mux_mode_i <= 1'b0;
		host_addr <= 16'h1234;
		wr(OFS_ADDR_DIR, 16'h0000);
		tick(3);
		rd(OFS_ADDR_DAT, 16'h1234);
		`CHK(q_var, 32'h00000000)
		// Strobe pin as interrupt, set up in the required order.
		pin_gpio_enable_i <= 16'h0004;
		mux_mode_i <= 1'b1;
		host_ctrl <= 9'h001;
		wr(OFS_CTRL_DIR, 16'h0000);
		wr(OFS_IRQ_INV, 16'h0000);
		wr(OFS_EVT_MASK, 16'h0007);
		wr(OFS_IRQ_EN, 16'h0004);
		tick(4);
		`CHK(pulses, 0)
		host_ctrl <= 9'h000;
		tick(6);
		`CHK(pulses, 1)
		`CHK(irq_o, 1'b1)
		rd(OFS_EVT_STAT, 16'h0001);
		rd(OFS_IRQ_EN, 16'h0004);
		wr(OFS_EVT_MASK, 16'h0000);
		tick(2);
		`CHK(irq_o, 1'b0)
		wr(OFS_EVT_STAT, 16'h0001);
		rd(OFS_EVT_STAT, 16'h0000);
		wr(OFS_IRQ_INV, 16'h0004);
		host_ctrl <= 9'h001;
		tick(6);
		`CHK(pulses, 2)
		wr(OFS_IRQ_EN, 16'h0000);
		host_ctrl <= 9'h000;
		tick(4);
		host_ctrl <= 9'h001;
		tick(6);
		`CHK(pulses, 2)
		// Host bit rise shares the same CPU interrupt.
		wr(OFS_EVT_MASK, 16'h0007);
		host_to_cpu_irq_bit_i <= 1'b1;
		tick(3);
		`CHK(pulses, 3)
		rd(OFS_EVT_STAT, 16'h0003);
		wr(OFS_EVT_STAT, 16'h0003);
		// Soft stop waits for the current operation; free overrides it.
		wr(OFS_EMU, 16'h0002);
		dma_busy_i <= 1'b1;
		emu_suspend_i <= 1'b1;
		tick(6);
		`CHK(dma_halt_o, 1'b0)
		dma_busy_i <= 1'b0;
		tick(4);
		`CHK(dma_halt_o, 1'b1)
		rd(OFS_EVT_STAT, 16'h0004);
		wr(OFS_EMU, 16'h0003);
		tick(3);
		`CHK(dma_halt_o, 1'b0)
		rd(OFS_EMU, 16'h0003);
		wr(OFS_EMU, 16'h0000);
		tick(4);
		`CHK(dma_halt_o, 1'b0)
		// A second reset in mid-run clears the registers again.
		rst_i <= 1'b1;
		tick(2);
		rst_i <= 1'b0;
		rd(OFS_IRQ_INV, 16'h0000);
		summarize();
	end
endmodule // hpgc_top_test
`default_nettype wire
